/* dv/pstm_host.sv */
// Host model: drives the link clock pair and the request pin.
// Assumes the bench sets run and req_in off the clk_sys edge.
`timescale 1ns/100ps
module pstm_host (
	input wire logic run,
	input wire logic req_in,
	output logic link_clock_pos,
	output logic link_clock_neg,
	output logic self_test_request_pin
);
	// Request level passes straight to the pin
	assign self_test_request_pin = req_in;
	// Pair toggles every 40 ns while running, else rests pos low
	initial begin
		link_clock_pos = 1'b0;
		forever #40 link_clock_pos = run ? ~link_clock_pos : 1'b0;
	end
	assign link_clock_neg = ~link_clock_pos;
endmodule

/* dv/pstm_mode_checker.sv */
// Checker: mode, pattern and timing relations at the controller pins.
// Assumes a bind to the controller that hands on its counts.
`timescale 1ns/100ps
module pstm_mode_checker import pstm_pkg::*; #(
	parameter int unsigned PAT_CYC = 50,
	parameter int unsigned BLACK_CYC = 80
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic self_test_request_pin,
	input wire logic link_clock_pos,
	input wire logic show_host_video,
	input wire logic show_black,
	input wire logic factory_test,
	input wire logic self_test_active,
	input wire logic [2:0] pattern_index,
	input wire logic [2:0] mode
);
	logic [31:0] tr_r, tr_nxt;
	logic [7:0] sc_r, sc_nxt;
	logic lk_r;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Black hold length and link quiet time
	always_comb begin
		tr_nxt = (mode == PSTM_TRANS) ? tr_r + 32'h1 : 32'h0;
		sc_nxt = (link_clock_pos != lk_r) ? 8'h0 : sc_r + {7'h0, ~&sc_r};
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tr_r <= 32'h0;
			sc_r <= 8'h0;
			lk_r <= 1'b0;
		end else begin
			tr_r <= tr_nxt;
			sc_r <= sc_nxt;
			lk_r <= link_clock_pos;
		end
	end
	sequence req_low;
		!self_test_request_pin [*6];
	endsequence
	pat_range_a: assert property (self_test_active |-> pattern_index < 3'h5)
		else $error("pattern index out of range");
	pat_step_a: assert property (self_test_active && $past(self_test_active)
		&& pattern_index != $past(pattern_index) |-> pattern_index ==
		($past(pattern_index) == 3'h4 ? 3'h0 : $past(pattern_index) + 3'h1))
		else $error("pattern step wrong");
	st_out_a: assert property (self_test_active |-> !show_host_video)
		else $error("video during self test");
	st_req_a: assert property (req_low |-> !self_test_active)
		else $error("self test without request");
	video_out_a: assert property (mode == PSTM_NORMAL |-> show_host_video)
		else $error("normal mode without video");
	black_stop_a: assert property (req_low ##0 sc_r > 8'h96 |-> show_black)
		else $error("stopped link not black");
	hold_norm_a: assert property (show_host_video && self_test_request_pin
		&& sc_r < 8'h40 |=> show_host_video) else $error("normal video left");
	trans_len_a: assert property (factory_test && $past(mode) == PSTM_TRANS
		|-> tr_r >= BLACK_CYC - 1 && tr_r <= BLACK_CYC + 1)
		else $error("black hold length wrong");
endmodule

/* dv/tb_top.sv */
// Bench: host model feeds the controller; outputs judged per scenario.
// Assumes shortened pattern and black counts set below.
`timescale 1ns/100ps
module tb_top import pstm_pkg::*; ;
	localparam int PAT = 50;
	localparam int BLK = 80;
	logic clk_sys = 1'b0, rst_n = 1'b0, run = 1'b0, req = 1'b0;
	logic lp, ln, pin, hv, bk, ft, st;
	logic [2:0] pi, md;
	int failures = 0, num_checks = 0;
	pstm_host pstm_host_i (.run(run), .req_in(req), .link_clock_pos(lp),
		.link_clock_neg(ln), .self_test_request_pin(pin));
	pstm_mode_ctl #(.PAT_CYC(PAT), .BLACK_CYC(BLK)) pstm_mode_ctl_i (
		.clk_sys(clk_sys), .rst_n(rst_n), .self_test_request_pin(pin),
		.link_clock_pos(lp), .link_clock_neg(ln), .show_host_video(hv),
		.show_black(bk), .factory_test(ft), .self_test_active(st),
		.pattern_index(pi), .mode(md));
	initial forever #5 clk_sys = ~clk_sys;
	task chk(string nm, logic [2:0] seen, logic [2:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task close_out();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Set link run and request, then let n cycles pass
	task go(logic r, logic q, int n);
		@(negedge clk_sys);
		run = r;
		req = q;
		repeat (n) @(negedge clk_sys);
	endtask
	task t_self();
		go(1'b0, 1'b1, 28);
		chk("self", st, 3'h1);
		for (int i = 1; i < 7; i++) begin
			repeat (PAT) @(negedge clk_sys);
			chk("pattern", pi, 3'(i % 5));
		end
	endtask
	task t_trans();
		go(1'b1, 1'b1, 20);
		chk("black", bk, 3'h1);
		repeat (BLK) @(negedge clk_sys);
		chk("factory", ft, 3'h1);
	endtask
	initial begin
		repeat (16) @(negedge clk_sys);
		rst_n = 1'b1;
		chk("reset", md, PSTM_PROTECT);
		go(1'b1, 1'b0, 20);
		chk("normal", md, PSTM_NORMAL);
		go(1'b1, 1'b1, 20);
		chk("hold", hv, 3'h1);
		go(1'b0, 1'b0, 150);
		chk("protect", md, PSTM_PROTECT);
		t_self();
		t_trans();
		go(1'b1, 1'b0, 10);
		chk("leave", md, PSTM_NORMAL);
		close_out();
	end
	initial begin
		#100us;
		failures++;
		close_out();
	end
endmodule
bind pstm_mode_ctl pstm_mode_checker #(.PAT_CYC(PAT_CYC),
	.BLACK_CYC(BLACK_CYC)) pstm_mode_checker_i (.clk_sys, .rst_n,
	.self_test_request_pin, .link_clock_pos, .show_host_video, .show_black,
	.factory_test, .self_test_active, .pattern_index, .mode);

/* rtl/pstm_act_if.sv */
// Interface carrying link activity from detector to mode control.
// Assumes both ends run on clk_sys.
`timescale 1ns/100ps
interface pstm_act_if;
	logic link_active;
	logic link_edge;

	modport det (output link_active, output link_edge);
	modport ctl (input link_active, input link_edge);
endinterface

/* rtl/pstm_cfg.svh */
// Constants for the panel self-test mode controller.
// Assumes inclusion by bare name; holds definitions only.
`ifndef PSTM_CFG_SVH
`define PSTM_CFG_SVH

// Clock rate of clk_sys in MHz
`define PSTM_CLK_MHZ 100
// Pattern interval, seconds
`define PSTM_PAT_SEC 2
// Black hold before factory test, seconds
`define PSTM_BLACK_SEC 5
// Pattern interval in cycles
`define PSTM_PAT_CYC (`PSTM_PAT_SEC * 1000000 * `PSTM_CLK_MHZ)
// Black hold in cycles
`define PSTM_BLACK_CYC (`PSTM_BLACK_SEC * 1000000 * `PSTM_CLK_MHZ)
// Link clock stopped timeout, nanoseconds
`define PSTM_STOP_NS 1000
// Stop timeout in cycles
`define PSTM_STOP_CYC (`PSTM_STOP_NS * `PSTM_CLK_MHZ / 1000)
// Number of test patterns
`define PSTM_NUM_PAT 5
// Reset pattern index
`define PSTM_PAT_RST 3'h0

`endif

/* rtl/pstm_link_det.sv */
// Link clock activity detector.
// Assumes link_clock_pos is asynchronous to clk_sys.
`timescale 1ns/100ps
`include "pstm_cfg.svh"
module pstm_link_det import pstm_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic link_clock_pos,
	pstm_act_if.det act
);

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		logic [31:0] idle_cnt;
		logic active;
		logic edge_seen;
	} pstm_det_t;

	pstm_det_t st_r;
	pstm_det_t st_nxt;

	// Synchronise pin, find edges, time out when none arrive
	always_comb begin
		st_nxt = st_r;
		st_nxt.sync1 = link_clock_pos;
		st_nxt.sync2 = st_r.sync1;
		st_nxt.prev = st_r.sync2;
		st_nxt.edge_seen = st_r.sync2 ^ st_r.prev;
		if (st_nxt.edge_seen) begin
			st_nxt.idle_cnt = 32'h0;
			st_nxt.active = 1'b1;
		end else if (st_r.idle_cnt >= 32'(`PSTM_STOP_CYC - 1)) begin
			st_nxt.active = 1'b0;
		end else begin
			st_nxt.idle_cnt = st_r.idle_cnt + 32'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign act.link_active = st_r.active;
	assign act.link_edge = st_r.edge_seen;

endmodule

/* rtl/pstm_mode_ctl.sv */
// Panel self-test mode control: chooses display behaviour.
// Assumes pins from the host are asynchronous to clk_sys.
// Assumes clk_sys keeps running while the link clock is stopped,
// since every interval is timed on it alone.
//
// Behaviour
// - Self-test cycles five internal images, two seconds each.
// - Self-test only with request pin high and link clock stopped.
// - Request low, clock running: show host video.
// - Request low, clock stopped: show black.
// - Request rising during normal video keeps normal video.
// - Request high, clock running, not from normal: black 5 s, factory.
`timescale 1ns/100ps
`include "pstm_cfg.svh"
module pstm_mode_ctl import pstm_pkg::*; #(
	parameter int unsigned PAT_CYC = `PSTM_PAT_CYC,
	parameter int unsigned BLACK_CYC = `PSTM_BLACK_CYC
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic self_test_request_pin,
	input wire logic link_clock_pos,
	input wire logic link_clock_neg,
	output logic show_host_video,
	output logic show_black,
	output logic factory_test,
	output logic self_test_active,
	output logic [2:0] pattern_index,
	output logic [2:0] mode
);

	// ------------------------------------------------------------
	// Link activity
	// ------------------------------------------------------------
	pstm_act_if act ();

	pstm_link_det u_det (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.link_clock_pos(link_clock_pos),
		.act(act)
	);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic req_s1;
		logic req_s2;
		pstm_mode_t mode;
		logic [31:0] tmr;
		logic [2:0] pat;
		logic video;
		logic black;
		logic factory;
		logic selftest;
	} pstm_ctl_t;

	pstm_ctl_t st_r;
	pstm_ctl_t st_nxt;

	// Negative leg is only the complement; steady level is host's duty
	logic unused_neg;
	assign unused_neg = link_clock_neg;

	// ------------------------------------------------------------
	// Input decode
	// ------------------------------------------------------------
	// Synchronised request level and link activity
	logic req;
	logic run;
	// One flag per cell of the operating mode table
	logic in_video;
	logic in_protect;
	logic in_selftest;
	logic in_trans;
	// Interval ends, timed on clk_sys and never on the link clock
	logic black_done;
	logic pat_done;
	logic pat_last;

	// Request has passed two stages; a fresh edge also counts as running
	assign req = st_r.req_s2;
	assign run = act.link_active || act.link_edge;
	// Table cells: request level against link activity
	assign in_video = !req && run;
	assign in_protect = !req && !run;
	assign in_selftest = req && !run;
	assign in_trans = req && run;
	// Interval ends on the internal time base
	assign black_done = (st_r.tmr >= BLACK_CYC - 32'h1);
	assign pat_done = (st_r.tmr >= PAT_CYC - 32'h1);
	assign pat_last = (st_r.pat == 3'(`PSTM_NUM_PAT - 1));

	// ------------------------------------------------------------
	// Mode selection and pattern timing
	// ------------------------------------------------------------
	// Inputs re-evaluated every cycle from every state
	always_comb begin
		st_nxt = st_r;
		st_nxt.req_s1 = self_test_request_pin;
		st_nxt.req_s2 = st_r.req_s1;
		st_nxt.tmr = st_r.tmr + 32'h1;
		case (st_r.mode)
			PSTM_NORMAL: begin
				// Request rising with video running is ignored
				if (in_protect) begin
					st_nxt.mode = PSTM_PROTECT;
				end else if (in_selftest) begin
					st_nxt.mode = PSTM_SELFTEST;
					st_nxt.tmr = 32'h0;
					st_nxt.pat = `PSTM_PAT_RST;
				end else begin
					st_nxt.mode = PSTM_NORMAL;
				end
			end

			PSTM_PROTECT: begin
				// Black until the inputs name another cell
				if (in_video) begin
					st_nxt.mode = PSTM_NORMAL;
				end else if (in_selftest) begin
					st_nxt.mode = PSTM_SELFTEST;
					st_nxt.tmr = 32'h0;
					st_nxt.pat = `PSTM_PAT_RST;
				end else if (in_trans) begin
					st_nxt.mode = PSTM_TRANS;
					st_nxt.tmr = 32'h0;
				end
			end

			PSTM_TRANS: begin
				// Black hold, then factory test
				if (in_video) begin
					st_nxt.mode = PSTM_NORMAL;
				end else if (in_protect) begin
					st_nxt.mode = PSTM_PROTECT;
				end else if (in_selftest) begin
					st_nxt.mode = PSTM_SELFTEST;
					st_nxt.tmr = 32'h0;
					st_nxt.pat = `PSTM_PAT_RST;
				end else if (black_done) begin
					st_nxt.mode = PSTM_FACTORY;
				end
			end

			PSTM_FACTORY: begin
				// Held while request high and link running
				if (in_video) begin
					st_nxt.mode = PSTM_NORMAL;
				end else if (in_protect) begin
					st_nxt.mode = PSTM_PROTECT;
				end else if (in_selftest) begin
					st_nxt.mode = PSTM_SELFTEST;
					st_nxt.tmr = 32'h0;
					st_nxt.pat = `PSTM_PAT_RST;
				end
			end

			PSTM_SELFTEST: begin
				// Rotate patterns until the inputs change
				if (in_video) begin
					st_nxt.mode = PSTM_NORMAL;
				end else if (in_protect) begin
					st_nxt.mode = PSTM_PROTECT;
				end else if (in_trans) begin
					st_nxt.mode = PSTM_TRANS;
					st_nxt.tmr = 32'h0;
				end else if (pat_done) begin
					st_nxt.tmr = 32'h0;
					if (pat_last) begin
						st_nxt.pat = `PSTM_PAT_RST;
					end else begin
						st_nxt.pat = st_r.pat + 3'h1;
					end
				end
			end

			default: begin
				// Unused codes fall back to the safe black screen
				st_nxt.mode = PSTM_PROTECT;
			end
		endcase
		// Outputs decoded ahead so they leave flip-flops directly
		st_nxt.video = (st_nxt.mode == PSTM_NORMAL);
		st_nxt.black = (st_nxt.mode == PSTM_PROTECT) ||
			(st_nxt.mode == PSTM_TRANS);
		st_nxt.factory = (st_nxt.mode == PSTM_FACTORY);
		st_nxt.selftest = (st_nxt.mode == PSTM_SELFTEST);
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Reset shows black protection
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.mode <= PSTM_PROTECT;
			st_r.black <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Every output is a field of the state register
	assign show_host_video = st_r.video;
	assign show_black = st_r.black;
	assign factory_test = st_r.factory;
	assign self_test_active = st_r.selftest;
	assign pattern_index = st_r.pat;
	assign mode = st_r.mode;

endmodule

/* rtl/pstm_pkg.sv */
// Types for the panel self-test mode controller.
// Assumes the constants header is on the include path.
package pstm_pkg;

	// Operating behaviour shown on the panel
	typedef enum logic [2:0] {
		PSTM_NORMAL,
		PSTM_PROTECT,
		PSTM_TRANS,
		PSTM_FACTORY,
		PSTM_SELFTEST
	} pstm_mode_t;

endpackage
